// file: rtl/cfg_pkg.sv
package cfg_pkg;

   // Address width of the external configuration memory.
   localparam int ADDR_W = 16;
   // Width of a parallel configuration word.
   localparam int WORD_W = 8;
   // Number of serial bits that form one word.
   localparam int SER_BITS = 8;
   // Address bits of the internal configuration RAM.
   localparam int RAM_AW = 12;
   // Header byte that must open every configuration file.
   localparam logic [7:0] PREAMBLE = 8'hb7;
   // Default word count of one configuration file.
   localparam int FILE_WORDS = 2677;
   // Reset values of the address, error flag and serial bit counter.
   localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
   localparam logic ERR_RST = 1'b0;
   localparam logic [2:0] CNT_RST = 3'h0;

   typedef enum logic [1:0]
   {
      ST_IDLE,
      ST_HEAD,
      ST_BODY,
      ST_DONE
   } cfg_state_e;

endpackage

// file: rtl/cfg_deser.sv
`timescale 1ns/100ps
`default_nettype none

// Gathers configuration bits into words, serial msb first or parallel.
module cfg_deser
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Control
   input wire logic clear,
   input wire logic serial_mode,
   input wire logic bit_stb,
   // Data in
   input wire logic config_serial_bit,
   input wire logic [cfg_pkg::WORD_W-1:0] par_data,
   // Word out
   output logic word_vld,
   output logic [cfg_pkg::WORD_W-1:0] word
);

   logic [cfg_pkg::WORD_W-1:0] sh_q;
   logic [2:0] cnt_q;
   logic vld_q;
   logic last_bit;
   logic [cfg_pkg::WORD_W-1:0] sh_next;

   assign last_bit = (cnt_q == 3'(cfg_pkg::SER_BITS - 1));
   assign sh_next = {sh_q[cfg_pkg::WORD_W-2:0], config_serial_bit};

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || clear)
      begin
         sh_q <= '0;
         cnt_q <= cfg_pkg::CNT_RST;
         vld_q <= 1'b0;
      end
      else
      begin
         vld_q <= bit_stb && (!serial_mode || last_bit);
         if (bit_stb && !serial_mode)
            sh_q <= par_data;
         else if (bit_stb)
         begin
            sh_q <= sh_next;
            cnt_q <= cnt_q + 3'h1;
         end
      end
   end

   assign word_vld = vld_q;
   assign word = sh_q;

endmodule

`default_nettype wire

// file: rtl/config_verify_cascade.sv
`timescale 1ns/100ps
`default_nettype none

module config_verify_cascade
#(
   parameter int FILE_WORDS = cfg_pkg::FILE_WORDS
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Configuration control
   input wire logic cfg_start,
   input wire logic configuration_clock,
   input wire logic serial_mode,
   input wire logic mem_fetch,
   input wire logic verify_n,
   // Options set by the initial programming
   input wire logic cascade_en,
   input wire logic err_en,
   // Configuration data
   input wire logic config_serial_bit,
   input wire logic [cfg_pkg::WORD_W-1:0] par_data,
   // External memory address
   output logic [cfg_pkg::ADDR_W-1:0] mem_addr,
   output logic mem_addr_oe,
   // Configuration RAM port
   output logic ram_we,
   output logic [cfg_pkg::RAM_AW-1:0] ram_addr,
   output logic [cfg_pkg::WORD_W-1:0] ram_wdata,
   input wire logic [cfg_pkg::WORD_W-1:0] ram_rdata,
   // Dual-function pins: configuration side
   output logic cascade_select_out_n,
   output logic cascade_oe,
   output logic err_n,
   output logic err_oe,
   // Dual-function pins: user side
   input wire logic user_cas_o,
   input wire logic user_cas_oe,
   input wire logic user_err_o,
   input wire logic user_err_oe,
   // Status
   output logic configuring,
   output logic cfg_done
);

   cfg_pkg::cfg_state_e st_q;
   cfg_pkg::cfg_state_e st_d;
   logic [cfg_pkg::ADDR_W-1:0] addr_q;
   logic [cfg_pkg::RAM_AW-1:0] waddr_q;
   logic [cfg_pkg::WORD_W-1:0] wdata_q;
   logic we_q;
   logic verify_q;
   logic err_q;
   logic configuration_clock_q;
   logic [15:0] words_q;
   logic cas_q;
   logic word_vld;
   logic [cfg_pkg::WORD_W-1:0] word;
   logic configuration_clock_rise;
   logic in_cfg;
   logic body_word;
   logic head_bad;
   logic mismatch;
   logic last_word;
   logic set_err;

   cfg_deser u_deser
   (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clear(cfg_start),
      .serial_mode(serial_mode),
      .bit_stb(configuration_clock_rise && in_cfg),
      .config_serial_bit(config_serial_bit),
      .par_data(par_data),
      .word_vld(word_vld),
      .word(word)
   );

   assign configuration_clock_rise = configuration_clock && !configuration_clock_q;
   assign in_cfg = (st_q == cfg_pkg::ST_HEAD) || (st_q == cfg_pkg::ST_BODY);
   assign body_word = word_vld && (st_q == cfg_pkg::ST_BODY);
   assign head_bad = word_vld && (st_q == cfg_pkg::ST_HEAD)
      && (word != cfg_pkg::PREAMBLE);
   // Stored data is read at waddr_q, one index below where the delayed write of a load puts that word.
   assign mismatch = body_word && verify_q && (word != ram_rdata);
   assign last_word = body_word && (words_q == 16'(FILE_WORDS - 1));
   assign set_err = mismatch || head_bad;

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         cfg_pkg::ST_IDLE:
            st_d = cfg_pkg::ST_IDLE;
         cfg_pkg::ST_HEAD:
            if (head_bad)
               st_d = cfg_pkg::ST_IDLE;
            else if (word_vld)
               st_d = cfg_pkg::ST_BODY;
         cfg_pkg::ST_BODY:
            if (last_word)
               st_d = cfg_pkg::ST_DONE;
         cfg_pkg::ST_DONE:
            st_d = cfg_pkg::ST_DONE;
         default:
            st_d = cfg_pkg::ST_IDLE;
      endcase
      if (cfg_start)
         st_d = cfg_pkg::ST_HEAD;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         st_q <= cfg_pkg::ST_IDLE;
      else
         st_q <= st_d;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         configuration_clock_q <= 1'b0;
      else
         configuration_clock_q <= configuration_clock;
   end

   // Verify choice is frozen for the whole cycle.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         verify_q <= 1'b0;
      else if (cfg_start)
         verify_q <= !verify_n;
   end

   // The address only moves on a detected rising edge of the clock.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || cfg_start)
         addr_q <= cfg_pkg::ADDR_RST;
      else if (configuration_clock_rise && in_cfg && mem_fetch)
         addr_q <= addr_q + 16'h0001;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || cfg_start)
      begin
         words_q <= 16'h0000;
         waddr_q <= '0;
      end
      else if (body_word)
      begin
         words_q <= words_q + 16'h0001;
         waddr_q <= waddr_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         we_q <= 1'b0;
         wdata_q <= '0;
      end
      else
      begin
         // A word that meets a restart is discarded, so it is never written.
         we_q <= body_word && !verify_q && !cfg_start;
         wdata_q <= word;
      end
   end

   // Error is cleared only by a new cycle, and a set in the same cycle
   // as a restart is dropped because the restart discards that word.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         err_q <= cfg_pkg::ERR_RST;
      else if (cfg_start)
         err_q <= 1'b0;
      else if (set_err)
         err_q <= 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         cas_q <= 1'b0;
      else
         cas_q <= (st_d == cfg_pkg::ST_DONE);
   end

   // Once configured, the error pin belongs to user logic; the cascade pin does too only when cascade_en is clear.
   assign cascade_select_out_n = (configuring || !cascade_en) ? user_cas_o
      : !cas_q;
   // The cascade pin stays driven through operation when cascading is used.
   assign cascade_oe = cascade_en ? 1'b1 : user_cas_oe;
   assign err_n = (configuring && err_en) ? !err_q : user_err_o;
   assign err_oe = (configuring && err_en) ? 1'b1 : user_err_oe;

   assign mem_addr = addr_q;
   assign mem_addr_oe = configuring && mem_fetch;
   assign ram_we = we_q;
   assign ram_addr = waddr_q;
   assign ram_wdata = wdata_q;
   assign configuring = (st_q != cfg_pkg::ST_DONE);
   assign cfg_done = (st_q == cfg_pkg::ST_DONE);

endmodule

`default_nettype wire

// file: bench/cfg_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_ram_model
(
   // Clock
   input wire logic clk_sys,
   // Configuration RAM port
   input wire logic ram_we,
   input wire logic [11:0] ram_addr,
   input wire logic [7:0] ram_wdata,
   output logic [7:0] ram_rdata
);
   logic [7:0] mem [4096];
   always_ff @(posedge clk_sys)
   begin
      if (ram_we)
         mem[ram_addr] <= ram_wdata;
   end
   assign ram_rdata = mem[ram_addr];
endmodule
`default_nettype wire

// file: bench/config_verify_cascade_sva.sv
`timescale 1ns/100ps
`default_nettype none
module cvc_sva
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Watched ports
   input wire logic cfg_start,
   input wire logic configuration_clock,
   input wire logic verify_n,
   input wire logic cascade_en,
   input wire logic err_en,
   input wire logic [cfg_pkg::ADDR_W-1:0] mem_addr,
   input wire logic ram_we,
   input wire logic cascade_select_out_n,
   input wire logic err_n,
   input wire logic user_cas_o,
   input wire logic user_err_o,
   input wire logic configuring
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   wire logic cfg_on = configuring && err_en;
   logic vfy_q;
   // Verify is taken at the start only, so later changes must not count.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         vfy_q <= 1'b0;
      else if (cfg_start)
         vfy_q <= !verify_n;
   end
   a_addr_step:
      assert property (!$stable(mem_addr) && !$past(cfg_start) |->
         $past(configuration_clock) || $past(configuration_clock, 2))
      else $error("address moved without clock rise");
   a_cas_done:
      assert property (cascade_en && !configuring |-> !cascade_select_out_n)
      else $error("cascade select high when done");
   a_cas_early:
      assert property (cascade_en && configuring && cascade_select_out_n
         |=> cascade_select_out_n || !configuring || !cascade_en)
      else $error("cascade select low during load");
   a_cas_user:
      assert property (!cascade_en |-> cascade_select_out_n == user_cas_o)
      else $error("cascade pin not user driven");
   a_err_user:
      assert property (!cfg_on |-> err_n == user_err_o)
      else $error("error pin not user driven");
   a_err_sticky:
      assert property (cfg_on && !err_n && !cfg_start ##1 cfg_on |-> !err_n)
      else $error("error cleared without restart");
   a_err_clear:
      assert property (cfg_start ##1 cfg_on |-> err_n)
      else $error("error kept over restart");
   a_verify_nowe:
      assert property (vfy_q |-> !ram_we)
      else $error("write during verify");
   c_done: cover property (cascade_en && $fell(configuring));
   c_err: cover property (vfy_q && $fell(err_n));
   c_write: cover property (ram_we);
endmodule
bind config_verify_cascade cvc_sva chk (.*);
`default_nettype wire

// file: bench/config_verify_cascade_tb.sv
`timescale 1ns/100ps
`default_nettype none
module config_verify_cascade_tb;
   logic clk_sys = 1'b0, rst_b = 1'b0, cfg_start = 1'b0, verify_n = 1'b1;
   logic configuration_clock = 1'b0, serial_mode = 1'b0, mem_fetch = 1'b1;
   logic cascade_en = 1'b1, err_en = 1'b1, config_serial_bit = 1'b0;
   logic user_cas_o, user_cas_oe, user_err_o, user_err_oe;
   logic [7:0] par_data = 8'h00, ram_rdata, ram_wdata, w [4], exp_q [$];
   logic [15:0] mem_addr;
   logic [11:0] ram_addr;
   logic mem_addr_oe, ram_we, cascade_select_out_n, cascade_oe;
   logic err_n, err_oe, configuring, cfg_done;
   int errors = 0, n_tests = 0, n_we = 0;
   config_verify_cascade #(.FILE_WORDS(4)) DUT (.*);
   cfg_ram_model ram (.*);
   always #10 clk_sys = ~clk_sys;
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("%0d checks, %0d errors", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Written words are looked at mid-cycle, where the registered port settles.
   always @(negedge clk_sys)
   begin
      if (ram_we === 1'b1)
      begin
         n_we++;
         chk("ram_wdata", exp_q.pop_front(), ram_wdata);
      end
   end
   // Clock high and low for two cycles each, above the minimum spacing.
   task automatic send(logic [7:0] d);
      for (int i = 7; i >= (serial_mode ? 0 : 7); i--)
      begin
         par_data = d;
         config_serial_bit = d[i];
         configuration_clock = 1'b1;
         repeat (2) @(negedge clk_sys);
         configuration_clock = 1'b0;
         repeat (2) @(negedge clk_sys);
      end
   endtask
   task automatic run(logic v, logic [7:0] h, int n, int bad);
      verify_n = v;
      cfg_start = 1'b1;
      @(negedge clk_sys);
      cfg_start = 1'b0;
      verify_n = 1'b1;
      chk("err_n", err_en ? 1'b1 : user_err_o, err_n);
      send(h);
      for (int k = 0; k < n; k++)
      begin
         if (v)
            exp_q.push_back(w[k]);
         send(w[k] ^ 8'(k == bad));
      end
      repeat (2) @(negedge clk_sys);
   endtask
   initial
   begin
      void'($urandom(80702));
      foreach (w[k])
         w[k] = 8'($urandom);
      {user_cas_o, user_cas_oe, user_err_o, user_err_oe} = 4'($urandom);
      repeat (12) @(negedge clk_sys);
      rst_b = 1'b1;
      run(1'b1, 8'hb7, 4, 9);
      chk("mem_addr", 16'h0005, mem_addr);
      chk("cas_n", 16'h0000, cascade_select_out_n);
      chk("err_n", 16'(user_err_o), err_n);
      chk("err_oe", 16'(user_err_oe), err_oe);
      chk("cascade_oe", 16'h0001, cascade_oe);
      chk("mem_addr_oe", 16'h0000, mem_addr_oe);
      chk("cfg_done", 16'h0001, cfg_done);
      serial_mode = 1'b1;
      run(1'b0, 8'hb7, 3, 1);
      chk("err_n", 16'h0000, err_n);
      chk("writes", 16'h0004, 16'(n_we));
      run(1'b1, 8'h5a, 0, 9);
      chk("err_n", 16'h0000, err_n);
      err_en = 1'b0;
      cascade_en = 1'b0;
      mem_fetch = 1'b0;
      run(1'b1, 8'h5a, 0, 9);
      chk("mem_addr", 16'h0000, mem_addr);
      chk("mem_addr_oe", 16'h0000, mem_addr_oe);
      chk("cascade_oe", 16'(user_cas_oe), cascade_oe);
      chk("err_oe", 16'(user_err_oe), err_oe);
      chk("cfg_done", 16'h0000, cfg_done);
      chk("err_n", 16'(user_err_o), err_n);
      chk("cas_n", 16'(user_cas_o), cascade_select_out_n);
      end_of_test();
   end
   initial
   begin
      #100000;
      errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
